// ===== tb/fan_pwm_tach_controller_tb.sv
`timescale 1ns/10ps
module fan_pwm_tach_controller_tb;
    logic aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, irq, boot_v;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdt, d, boot_p;
    logic [1:0] bresp, rresp, r;
    logic [3:0] tach, gate;
    int fail_count, compares, n, on;
    // address, expected data, expected response
    logic [41:0] rows [7] = '{{8'h00, 32'h0, 2'h0}, {8'h04, 32'h1, 2'h0}, {8'h08, 32'h8, 2'h0},
        {8'h10, 32'h0, 2'h0}, {8'h20, 32'h64, 2'h0}, {8'h2c, 32'h64, 2'h0}, {8'h1c, 32'h0, 2'h2}};

    fpt_top #(.PWM_PERIOD_CYC(400), .MEAS_WIN_CYC(64), .STAGGER_CYC(32), .GLITCH_TICK_CYC(4))
    fpt_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .boot_pwr_valid(boot_v),
        .boot_pwr(boot_p), .tach_pin(tach), .fan_gate(gate), .irq(irq));
    fpt_fan_model fpt_fan_model_i (.aclk(aclk), .fan_gate(gate), .tach_pin(tach));

    ////////////////////////////////////////////////////////////////////////////
    // checking and closing
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // bus master: hold each channel until its handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (!(bv && br) && n < 50);
        br <= 1'b0;
        chk("bresp", bresp, 2'h0);
        if (n >= 50) begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arv && arr) arv <= 1'b0;
        end while (!rv && n < 50);
        d = rdt;
        r = rresp;
        rr <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            stop_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // main sequence
    initial begin
        {aresetn, awv, wv, br, arv, rr, awa, ara, wd, boot_v, boot_p} = '0;
        fail_count = 0;
        compares = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("stagger0", gate, 4'h1);
        repeat (40) @(posedge aclk);
        chk("stagger1", gate, 4'h3);
        foreach (rows[i]) begin
            rd(rows[i][41:34]);
            chk("rdata", d, rows[i][33:2]);
            chk("rresp", r, rows[i][1:0]);
        end
        repeat (80) @(posedge aclk);
        chk("all on", gate, 4'hf);
        // every window flags its result
        wr(8'h10, 32'h1f);
        repeat (300) @(posedge aclk);
        chk("irq", irq, 1'b1);
        rd(8'h0c);
        chk("ready", d[3:0], 4'hf);
        rd(8'h30);
        chk("counted", d != 0, 1'b1);
        // over-range clamps, half power gives half duty
        wr(8'h20, 32'hc8);
        rd(8'h20);
        chk("clamp", d, 32'h64);
        wr(8'h20, 32'h32);
        on = 0;
        repeat (400) begin
            @(posedge aclk);
            on += gate[0];
        end
        chk("duty", on, 200);
        // zero power, then report on fan 3 and fail-safe on fans 0 and 2
        wr(8'h28, 32'h0);
        wr(8'h2c, 32'h0);
        @(posedge aclk);
        chk("off", gate[3:2], 2'h0);
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h58);
        wr(8'h28, 32'h0);
        for (n = 0; n < 300 && gate[3] !== 1'b1; n++) @(posedge aclk);
        chk("forced", gate[3], 1'b1);
        for (n = 0; n < 70 && gate[3] !== 1'b0; n++) @(posedge aclk);
        chk("released", gate[3], 1'b0);
        for (n = 0; n < 300 && gate[2] !== 1'b1; n++) @(posedge aclk);
        chk("failsafe", gate[2], 1'b1);
        wr(8'h28, 32'h0);
        @(posedge aclk);
        chk("rearmed", gate[2], 1'b0);
        // second reset: stored power, fan 0 stored at zero and skipped
        aresetn <= 1'b0;
        boot_v <= 1'b1;
        boot_p <= 32'h32c8_1400;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("rst irq", irq, 1'b0);
        chk("rst gate", gate, 4'h0);
        repeat (44) @(posedge aclk);
        chk("skip", {gate[3:2], gate[0]}, 3'h2);
        rd(8'h24);
        chk("boot1", d, 32'h14);
        rd(8'h28);
        chk("boot2", d, 32'h64);
        rd(8'h2c);
        chk("boot3", d, 32'h32);
        stop_test();
    end
endmodule

// ===== tb/fpt_fan_model.sv
`timescale 1ns/10ps
module fpt_fan_model #(
    parameter int HALF = 4
) (
    // clock and fan power
    input wire logic aclk,
    input wire logic [3:0] fan_gate,
    // tach lines, pulled up while a fan stands
    output logic [3:0] tach_pin
);
    int cnt [4];
    initial tach_pin = 4'hf;
    // a powered fan toggles its tach, higher fans a little slower
    always @(posedge aclk) begin
        for (int i = 0; i < 4; i++) begin
            if (fan_gate[i]) begin
                cnt[i] <= (cnt[i] >= HALF + i) ? 0 : cnt[i] + 1;
                if (cnt[i] >= HALF + i) tach_pin[i] <= ~tach_pin[i];
            end else begin
                tach_pin[i] <= 1'b1; // unpowered fan: pull-up wins
            end
        end
    end
endmodule

// ===== verilog/fpt_pkg.sv
package fpt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // fan count and clock
    localparam int FAN_NUM = 4;
    localparam int CLK_HZ = 25000000;

    ////////////////////////////////////////////////////////////////////////////
    // times in their own units
    localparam int PWM_FREQ_HZ = 18;
    localparam int MEAS_WIN_MS = 125;
    localparam int STAGGER_MS = 500;
    localparam int GLITCH_TICK_MS = 1;

    // times as clock cycles
    localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
    localparam int MEAS_WIN_CYC = CLK_HZ / 1000 * MEAS_WIN_MS;
    localparam int STAGGER_CYC = CLK_HZ / 1000 * STAGGER_MS;
    localparam int GLITCH_TICK_CYC = CLK_HZ / 1000 * GLITCH_TICK_MS;

    ////////////////////////////////////////////////////////////////////////////
    // power scale: 0 to 100 percent
    localparam logic [6:0] PWR_FULL = 7'h64;
    localparam int PWR_STEPS = 100;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets and pages
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GLITCH = 8'h04;
    localparam logic [7:0] ADDR_FS_INT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_STATE = 8'h14;
    localparam logic [3:0] PAGE_POWER = 4'h2;
    localparam logic [3:0] PAGE_RESULT = 4'h3;

    // field positions
    localparam int CTRL_REP_LSB = 0;
    localparam int CTRL_FS_LSB = 4;
    localparam int STAT_FS_BIT = 4;
    localparam int STATE_FORCE_LSB = 4;
    localparam int STATE_START_LSB = 8;
    localparam int STATE_FSACT_BIT = 12;
    localparam int STATE_MEAS_LSB = 13;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] GLITCH_RST = 8'h01;
    localparam logic [7:0] FS_INT_RST = 8'h08;
    localparam logic [4:0] MASK_RST = 5'h00;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // start-up sequencer
    typedef enum logic [1:0] {
        FPT_SQ_CHECK = 2'h0,
        FPT_SQ_DELAY = 2'h1,
        FPT_SQ_DONE = 2'h3
    } fpt_seq_t;

endpackage

// ===== verilog/fpt_tach_edge.sv
`timescale 1ns/10ps
module fpt_tach_edge #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // raw tachometer pins
    input wire logic [N-1:0] tach_pin,
    // one-cycle rising edge pulses
    output logic [N-1:0] tach_rise
);

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser, then edge detect, per fan
    for (genvar i = 0; i < N; i++) begin : g_ch
        logic meta_r;
        logic sync_r;
        logic prev_r;
        logic rise_r;
        always_ff @(posedge aclk) begin
            // reset to the pulled-up idle level so release gives no false edge
            if (!aresetn) begin
                meta_r <= 1'b1;
                sync_r <= 1'b1;
                prev_r <= 1'b1;
                rise_r <= 1'b0;
            end else begin
                meta_r <= tach_pin[i];
                sync_r <= meta_r;
                prev_r <= sync_r;
                rise_r <= sync_r & ~prev_r;
            end
        end
        assign tach_rise[i] = rise_r;
    end

endmodule

// ===== verilog/fpt_top.sv
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - four independent fan power and tach channels
// - power setting zero to full sets duty
// - fan PWM runs at nominally 18 Hz
// - tach frequency averaged over 125 ms window
// - windows rotate fans, each refreshed every 500 ms
// - reporting fan forced full at window start
// - force holds until glitch delay and two edges
// - stretched on-pulse never exceeds 125 ms
// - tach results readable for speed computation
// - fail-safe drives fan full on host silence
// - boot power from stored value, else full
// - fans started one by one, 0.5 s apart
module fpt_top #(
    parameter int PWM_PERIOD_CYC = fpt_pkg::PWM_PERIOD_CYC,
    parameter int MEAS_WIN_CYC = fpt_pkg::MEAS_WIN_CYC,
    parameter int STAGGER_CYC = fpt_pkg::STAGGER_CYC,
    parameter int GLITCH_TICK_CYC = fpt_pkg::GLITCH_TICK_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // stored boot configuration
    input wire logic boot_pwr_valid,
    input wire logic [31:0] boot_pwr,
    // fans
    input wire logic [3:0] tach_pin,
    output logic [3:0] fan_gate,
    // interrupt
    output logic irq
);

    localparam int PW = $clog2(PWM_PERIOD_CYC);
    localparam int WW = $clog2(MEAS_WIN_CYC);
    localparam int SW = $clog2(STAGGER_CYC);
    localparam int GW = $clog2(GLITCH_TICK_CYC);
    localparam int STEP_CYC = PWM_PERIOD_CYC / fpt_pkg::PWR_STEPS;

    if (PWM_PERIOD_CYC < 200 || MEAS_WIN_CYC < 16 || STAGGER_CYC < 16
            || GLITCH_TICK_CYC < 2) begin : g_bad
        $error("fpt_top: timing parameters too small");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic wr_en, wr_ok, rd_en, rd_ok, pwr_wr;
    logic [31:0] rd_val;
    logic [7:0] ctrl_r, glitch_r, fs_int_r;
    logic [4:0] status_r, mask_r, stat_set, stat_clr;
    logic irq_r, boot_done_r;
    logic [6:0] pwr_r [fpt_pkg::FAN_NUM];
    logic [6:0] eff_pwr [fpt_pkg::FAN_NUM];
    logic [7:0] result_r [fpt_pkg::FAN_NUM];
    logic [3:0] ctrl_rep, ctrl_fs, gate_nxt, gate_r, force_r, started_r, tach_rise;
    logic [PW-1:0] phase_r;
    logic [WW-1:0] win_cnt_r;
    logic win_end;
    logic [1:0] meas_r, meas_next, seq_idx_r;
    logic [GW-1:0] gtick_r;
    logic [7:0] glitch_rem_r, edge_cnt_r, fs_cnt_r;
    logic fs_active_r, fs_fire;
    logic [SW-1:0] seq_cnt_r;
    fpt_pkg::fpt_seq_t seq_r;

    function automatic logic [6:0] clamp_pwr(input logic [7:0] v);
        clamp_pwr = (v > {1'b0, fpt_pkg::PWR_FULL}) ? fpt_pkg::PWR_FULL : v[6:0];
    endfunction

    assign ctrl_rep = ctrl_r[fpt_pkg::CTRL_REP_LSB +: 4];
    assign ctrl_fs = ctrl_r[fpt_pkg::CTRL_FS_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////
    // axi write: address and data taken in either order
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready = !w_hold_r;
    assign wr_en = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_ok = (awaddr_r[1:0] == 2'h0) && (awaddr_r == fpt_pkg::ADDR_CTRL
        || awaddr_r == fpt_pkg::ADDR_GLITCH || awaddr_r == fpt_pkg::ADDR_FS_INT
        || awaddr_r == fpt_pkg::ADDR_MASK || awaddr_r[7:4] == fpt_pkg::PAGE_POWER);
    assign pwr_wr = wr_en && wr_ok && wstrb_r[0] && awaddr_r[7:4] == fpt_pkg::PAGE_POWER;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bresp_r <= fpt_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? fpt_pkg::RESP_OKAY : fpt_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // configuration registers, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= fpt_pkg::CTRL_RST;
            glitch_r <= fpt_pkg::GLITCH_RST;
            fs_int_r <= fpt_pkg::FS_INT_RST;
            mask_r <= fpt_pkg::MASK_RST;
        end else if (wr_en && wstrb_r[0]) begin
            case (awaddr_r)
                fpt_pkg::ADDR_CTRL: ctrl_r <= wdata_r[7:0];
                fpt_pkg::ADDR_GLITCH: glitch_r <= wdata_r[7:0];
                fpt_pkg::ADDR_FS_INT: fs_int_r <= wdata_r[7:0];
                fpt_pkg::ADDR_MASK: mask_r <= wdata_r[4:0];
                default: ;
            endcase
        end
    end

    // power settings: full at reset, stored value once after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_done_r <= 1'b0;
            for (int i = 0; i < fpt_pkg::FAN_NUM; i++) begin
                pwr_r[i] <= fpt_pkg::PWR_FULL;
            end
        end else if (!boot_done_r) begin
            boot_done_r <= 1'b1;
            if (boot_pwr_valid) begin
                for (int i = 0; i < fpt_pkg::FAN_NUM; i++) begin
                    pwr_r[i] <= clamp_pwr(boot_pwr[8*i +: 8]);
                end
            end
        end else if (pwr_wr) begin
            pwr_r[awaddr_r[3:2]] <= clamp_pwr(wdata_r[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read: one word per read, status cleared by its read
    assign s_axi_arready = !rvalid_r;
    assign rd_en = s_axi_arvalid && !rvalid_r;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = (s_axi_araddr[1:0] == 2'h0);
        case (s_axi_araddr)
            fpt_pkg::ADDR_CTRL: rd_val[7:0] = ctrl_r;
            fpt_pkg::ADDR_GLITCH: rd_val[7:0] = glitch_r;
            fpt_pkg::ADDR_FS_INT: rd_val[7:0] = fs_int_r;
            fpt_pkg::ADDR_STATUS: rd_val[4:0] = status_r;
            fpt_pkg::ADDR_MASK: rd_val[4:0] = mask_r;
            fpt_pkg::ADDR_STATE: rd_val[14:0] = {meas_r, fs_active_r, started_r, force_r, gate_r};
            default: begin
                if (s_axi_araddr[7:4] == fpt_pkg::PAGE_POWER) begin
                    rd_val[6:0] = pwr_r[s_axi_araddr[3:2]];
                end else if (s_axi_araddr[7:4] == fpt_pkg::PAGE_RESULT) begin
                    rd_val[7:0] = result_r[s_axi_araddr[3:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= fpt_pkg::RESP_OKAY;
        end else if (rd_en) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_ok ? rd_val : 32'h0000_0000;
            rresp_r <= rd_ok ? fpt_pkg::RESP_OKAY : fpt_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status, set wins over read clear; level interrupt
    assign stat_set = {fs_fire, win_end ? (4'h1 << meas_r) : 4'h0};
    assign stat_clr = (rd_en && s_axi_araddr == fpt_pkg::ADDR_STATUS) ? status_r : 5'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= 5'h00;
            irq_r <= 1'b0;
        end else begin
            status_r <= (status_r & ~stat_clr) | stat_set;
            irq_r <= |(status_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pwm phase counter shared by all fans
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= '0;
        end else if (phase_r == PW'(PWM_PERIOD_CYC - 1)) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    // per-fan effective power and gate drive
    for (genvar f = 0; f < fpt_pkg::FAN_NUM; f++) begin : g_fan
        logic [PW-1:0] thr;
        assign eff_pwr[f] = (fs_active_r && ctrl_fs[f]) ? fpt_pkg::PWR_FULL : pwr_r[f];
        assign thr = PW'(STEP_CYC * int'(eff_pwr[f]));
        assign gate_nxt[f] = started_r[f] && (force_r[f] || eff_pwr[f] >= fpt_pkg::PWR_FULL
            || phase_r < thr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_r <= 4'h0;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up sequencer: one fan per stagger delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_r <= fpt_pkg::FPT_SQ_CHECK;
            seq_idx_r <= 2'h0;
            seq_cnt_r <= '0;
            started_r <= 4'h0;
        end else begin
            case (seq_r)
                fpt_pkg::FPT_SQ_CHECK: begin
                    if (boot_done_r) begin
                        if (eff_pwr[seq_idx_r] != 7'h00) begin
                            started_r[seq_idx_r] <= 1'b1;
                            seq_cnt_r <= '0;
                            seq_r <= fpt_pkg::FPT_SQ_DELAY;
                        end else if (seq_idx_r == 2'h3) begin
                            seq_r <= fpt_pkg::FPT_SQ_DONE;
                        end else begin
                            seq_idx_r <= seq_idx_r + 2'h1;
                        end
                    end
                end
                fpt_pkg::FPT_SQ_DELAY: begin
                    if (seq_cnt_r == SW'(STAGGER_CYC - 1)) begin
                        if (seq_idx_r == 2'h3) begin
                            seq_r <= fpt_pkg::FPT_SQ_DONE;
                        end else begin
                            seq_idx_r <= seq_idx_r + 2'h1;
                            seq_r <= fpt_pkg::FPT_SQ_CHECK;
                        end
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 1'b1;
                    end
                end
                fpt_pkg::FPT_SQ_DONE: started_r <= 4'hf;
                default: seq_r <= fpt_pkg::FPT_SQ_CHECK;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurement window and fan rotation
    assign win_end = (win_cnt_r == WW'(MEAS_WIN_CYC - 1));
    assign meas_next = meas_r + 2'h1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt_r <= '0;
            meas_r <= 2'h0;
        end else if (win_end) begin
            win_cnt_r <= '0;
            meas_r <= meas_next;
        end else begin
            win_cnt_r <= win_cnt_r + 1'b1;
        end
    end

    // glitch delay countdown from the start of each window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gtick_r <= '0;
            glitch_rem_r <= fpt_pkg::GLITCH_RST; // first window waits out the glitch delay too
        end else if (win_end) begin
            gtick_r <= '0;
            glitch_rem_r <= glitch_r;
        end else if (glitch_rem_r != 8'h00) begin
            if (gtick_r == GW'(GLITCH_TICK_CYC - 1)) begin
                gtick_r <= '0;
                glitch_rem_r <= glitch_rem_r - 8'h01;
            end else begin
                gtick_r <= gtick_r + 1'b1;
            end
        end
    end

    // edge count of the measured fan, saved per fan at window end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_cnt_r <= 8'h00;
            for (int i = 0; i < fpt_pkg::FAN_NUM; i++) begin
                result_r[i] <= 8'h00;
            end
        end else if (win_end) begin
            edge_cnt_r <= 8'h00;
            result_r[meas_r] <= edge_cnt_r;
        end else if (glitch_rem_r == 8'h00 && tach_rise[meas_r] && edge_cnt_r != 8'hff) begin
            edge_cnt_r <= edge_cnt_r + 8'h01;
        end
    end

    // forced full power for a reporting fan during its window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            force_r <= 4'h0;
        end else if (win_end) begin
            force_r <= ctrl_rep & (4'h1 << meas_next);
        end else if (glitch_rem_r == 8'h00 && edge_cnt_r >= 8'h02) begin
            force_r <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fail-safe timer in window ticks, restarted by power writes
    assign fs_fire = win_end && !fs_active_r && !pwr_wr && fs_cnt_r == fs_int_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_cnt_r <= 8'h00;
            fs_active_r <= 1'b0;
        end else if (pwr_wr) begin
            fs_cnt_r <= 8'h00;
            fs_active_r <= 1'b0;
        end else if (fs_fire) begin
            fs_active_r <= 1'b1;
        end else if (win_end && !fs_active_r) begin
            fs_cnt_r <= fs_cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tachometer inputs
    fpt_tach_edge #(.N(fpt_pkg::FAN_NUM)) u_tach (
        .aclk(aclk),
        .aresetn(aresetn),
        .tach_pin(tach_pin),
        .tach_rise(tach_rise)
    );

    // outputs
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign fan_gate = gate_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_seq_start;
        seq_r == fpt_pkg::FPT_SQ_CHECK && boot_done_r && eff_pwr[seq_idx_r] != 7'h00;
    endsequence
    sequence s_seq_wait;
        seq_r == fpt_pkg::FPT_SQ_DELAY [*8];
    endsequence

    property p_force_start;
        @(posedge aclk) disable iff (!aresetn)
        win_end && ctrl_rep[meas_next] |=> force_r[meas_r];
    endproperty
    a_force_start: assert property (p_force_start) else $error("force missing");

    property p_force_only_meas;
        @(posedge aclk) disable iff (!aresetn)
        (force_r & ~(4'h1 << meas_r)) == 4'h0;
    endproperty
    a_force_only_meas: assert property (p_force_only_meas) else $error("force outlived window");

    property p_force_release;
        @(posedge aclk) disable iff (!aresetn)
        !win_end && glitch_rem_r == 8'h00 && edge_cnt_r >= 8'h02 |=> force_r == 4'h0;
    endproperty
    a_force_release: assert property (p_force_release) else $error("force not released");

    property p_edge_gate;
        @(posedge aclk) disable iff (!aresetn)
        !win_end && glitch_rem_r != 8'h00 |=> $stable(edge_cnt_r);
    endproperty
    a_edge_gate: assert property (p_edge_gate) else $error("edge counted in glitch delay");

    property p_rotate;
        @(posedge aclk) disable iff (!aresetn)
        win_end |=> (meas_r == $past(meas_r) + 2'h1) ##1 !win_end [*8];
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotation wrong");

    property p_failsafe;
        @(posedge aclk) disable iff (!aresetn)
        fs_active_r && ctrl_fs[0] && started_r[0] |=> fan_gate[0];
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("fail-safe not full");

    property p_fs_restart;
        @(posedge aclk) disable iff (!aresetn)
        pwr_wr |=> fs_cnt_r == 8'h00 && !fs_active_r;
    endproperty
    a_fs_restart: assert property (p_fs_restart) else $error("fail-safe not restarted");

    property p_stagger;
        @(posedge aclk) disable iff (!aresetn)
        s_seq_start |=> s_seq_wait;
    endproperty
    a_stagger: assert property (p_stagger) else $error("start-up too fast");

    property p_boot;
        @(posedge aclk) disable iff (!aresetn)
        !boot_done_r && boot_pwr_valid && boot_pwr[7:0] <= 8'h64
            |=> pwr_r[0] == $past(boot_pwr[6:0]);
    endproperty
    a_boot: assert property (p_boot) else $error("boot power not loaded");

    property p_zero_off;
        @(posedge aclk) disable iff (!aresetn)
        eff_pwr[0] == 7'h00 && !force_r[0] |=> !fan_gate[0];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero power drives fan");

endmodule
